/* hw/crcbu_top.sv */
/*
 byte-wide crc16 unit with an apb register slave, an input buffer and the remainder engine.
 assumes an apb master on sys_clk; no other partner, no interrupt.
*/
`default_nettype none
module crcbu_top
   import crcbu_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // remainder status
   output logic [15:0] crc_value
);
   crcbu_byte_if wr_if ();
   crcbu_byte_if eng_if ();
   logic [7:0] result_low_r;
   logic [7:0] result_high_r;
   logic [15:0] fold_nxt;
   crcbu_sel_t sel;
   logic access;
   logic in_wr;
   logic busy;

   // address decode, used by both the read path and the write path
   function automatic crcbu_sel_t decode(input logic [31:0] addr);
      if (addr[31:CRCBU_ADDR_W] != '0) begin
         decode = CRCBU_SEL_NONE;
      end else begin
         case (addr[CRCBU_ADDR_W-1:0])
            CRCBU_ADDR_RESULT_LOW: decode = CRCBU_SEL_LOW;
            CRCBU_ADDR_RESULT_HIGH: decode = CRCBU_SEL_HIGH;
            CRCBU_ADDR_DATA_INPUT: decode = CRCBU_SEL_IN;
            default: decode = CRCBU_SEL_NONE;
         endcase
      end
   endfunction

   // one byte folded into the remainder, lsb first, reflected feedback
   function automatic logic [15:0] crc_fold(input logic [15:0] rem, input logic [7:0] din);
      logic [15:0] c;
      c = rem ^ {8'h00, din};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRCBU_POLY_REFL) : (c >> 1);
      end
      crc_fold = c;
   endfunction

   // bus access decode
   assign sel = decode(paddr);
   assign access = psel && penable && pready;
   // a write to the input register waits only while the buffer is full
   assign in_wr = psel && penable && pwrite && (sel == CRCBU_SEL_IN) && pstrb[0];
   assign busy = eng_if.valid;

   // ready: input writes stall on a full buffer; result reads and writes wait until pending bytes are folded
   always_comb begin
      pready = 1'b1;
      if (psel && penable) begin
         if (in_wr) begin
            pready = wr_if.ready;
         end else if (!pwrite && (sel == CRCBU_SEL_LOW || sel == CRCBU_SEL_HIGH)) begin
            pready = !busy;
         end else if (pwrite && (sel == CRCBU_SEL_LOW || sel == CRCBU_SEL_HIGH)) begin
            pready = !busy;
         end
      end
   end

   // bytes into the buffer
   assign wr_if.valid = in_wr;
   assign wr_if.data = pwdata[7:0];

   crcbu_buf u_buf (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_if(wr_if.dst),
      .out_if(eng_if.src)
   );

   // engine takes one byte per cycle
   assign eng_if.ready = 1'b1;
   assign fold_nxt = crc_fold({result_high_r, result_low_r}, eng_if.data);

   // low result byte
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         result_low_r <= CRCBU_RESULT_LOW_RST;
      end else if (eng_if.valid) begin
         result_low_r <= fold_nxt[7:0];
      end else if (access && pwrite && sel == CRCBU_SEL_LOW && pstrb[0]) begin
         result_low_r <= pwdata[7:0];
      end
   end

   // high result byte
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         result_high_r <= CRCBU_RESULT_HIGH_RST;
      end else if (eng_if.valid) begin
         result_high_r <= fold_nxt[15:8];
      end else if (access && pwrite && sel == CRCBU_SEL_HIGH && pstrb[0]) begin
         result_high_r <= pwdata[7:0];
      end
   end

   // outputs: prdata must be valid in the access cycle, so it is the live value
   // of the result flops; the input register reads as zero
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (psel && penable && !pwrite) begin
         case (sel)
            CRCBU_SEL_LOW: prdata = {24'h00_0000, result_low_r};
            CRCBU_SEL_HIGH: prdata = {24'h00_0000, result_high_r};
            default: prdata = 32'h0000_0000;
         endcase
      end
      if (psel && penable) begin
         pslverr = (sel == CRCBU_SEL_NONE);
      end
   end

   // remainder shown as status
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         crc_value <= {CRCBU_RESULT_HIGH_RST, CRCBU_RESULT_LOW_RST};
      end else begin
         crc_value <= eng_if.valid ? fold_nxt : {result_high_r, result_low_r};
      end
   end
endmodule
`default_nettype wire

/* hw/crcbu_pkg.sv */
/*
 package for the byte-wide crc16 unit: register map, reset values, polynomial, buffer geometry, register select.
 assumes an apb slave on a 200 mhz system clock with synchronous active-high reset.
*/
`default_nettype none
package crcbu_pkg;
   // register offsets (printed offsets are not word aligned, so they are indices)
   localparam logic [11:0] CRCBU_IDX_RESULT_LOW = 12'h187;
   localparam logic [11:0] CRCBU_IDX_RESULT_HIGH = 12'h188;
   localparam logic [11:0] CRCBU_IDX_DATA_INPUT = 12'h189;
   localparam int CRCBU_ADDR_W = 14;
   localparam logic [13:0] CRCBU_ADDR_RESULT_LOW = {CRCBU_IDX_RESULT_LOW, 2'b00};
   localparam logic [13:0] CRCBU_ADDR_RESULT_HIGH = {CRCBU_IDX_RESULT_HIGH, 2'b00};
   localparam logic [13:0] CRCBU_ADDR_DATA_INPUT = {CRCBU_IDX_DATA_INPUT, 2'b00};
   // reset values and the reflected feedback constant
   localparam logic [7:0] CRCBU_RESULT_LOW_RST = 8'hff;
   localparam logic [7:0] CRCBU_RESULT_HIGH_RST = 8'hff;
   localparam logic [15:0] CRCBU_POLY_REFL = 16'ha001;
   // buffer geometry
   localparam int CRCBU_BUF_DEPTH = 2;
   localparam int CRCBU_BUF_W = 8;
   // register select decoded from the bus address
   typedef enum logic [1:0] {CRCBU_SEL_NONE, CRCBU_SEL_LOW, CRCBU_SEL_HIGH, CRCBU_SEL_IN}
      crcbu_sel_t;
endpackage
`default_nettype wire

/* hw/crcbu_byte_if.sv */
/*
 interface carrying input bytes from the bus slave through the buffer into the crc engine.
 assumes one clock domain; valid/ready handshake, a word moves when both are high.
*/
`default_nettype none
interface crcbu_byte_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

/* hw/crcbu_buf.sv */
/*
 two-entry buffer for input bytes with valid and ready on both sides.
 assumes the drain side may stall; full refuses, empty shows no valid.
*/
`default_nettype none
module crcbu_buf
   import crcbu_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // fill and drain sides
   crcbu_byte_if.dst in_if,
   crcbu_byte_if.src out_if
);
   logic [CRCBU_BUF_W-1:0] mem_r [CRCBU_BUF_DEPTH];
   logic wr_ptr_r;
   logic rd_ptr_r;
   logic [1:0] count_r;
   logic push;
   logic pop;

   // handshake terms
   assign in_if.ready = (count_r != 2'(CRCBU_BUF_DEPTH));
   assign out_if.valid = (count_r != 2'h0);
   assign out_if.data = mem_r[rd_ptr_r];
   assign push = in_if.valid && in_if.ready;
   assign pop = out_if.valid && out_if.ready;

   // storage
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_if.data;
      end
   end

   // pointers and fill level
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + 2'(push) - 2'(pop);
      end
   end
endmodule
`default_nettype wire

/* testbench/crcbu_properties.sv */
/* port checker for the crc16 unit.
 bound to crcbu_top; one clock, sync active-high reset. */
`default_nettype none
module crcbu_properties
   import crcbu_pkg::*;
(
   // clock, reset, bus and status
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] crc_value
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // access phase and a taken byte write
   logic acc;
   logic tk;
   assign acc = psel && penable;
   assign tk = acc && pready && pwrite && pstrb[0];
   sequence s_wr(a);
      tk && paddr == a;
   endsequence
   a_reset_ones: assert property ($fell(sys_rst) |-> crc_value == 16'hffff)
      else $error("remainder not all ones after reset");
   a_change_cause: assert property ($changed(crc_value) |->
      $past(tk) || $past(tk, 2) || $past(tk, 3) || $past(tk, 4))
      else $error("remainder moved without a write");
   a_ready_bound: assert property (acc |-> ##[0:2] pready)
      else $error("access not answered in time");
   a_setup_noerr: assert property (psel && !penable |-> !pslverr)
      else $error("error flagged in setup");
   a_err_unmapped: assert property (acc && paddr != CRCBU_ADDR_RESULT_LOW &&
      paddr != CRCBU_ADDR_RESULT_HIGH && paddr != CRCBU_ADDR_DATA_INPUT |-> pslverr)
      else $error("unmapped access not flagged");
   a_in_rdzero: assert property (acc && !pwrite && paddr == CRCBU_ADDR_DATA_INPUT
      |-> prdata == 32'h0)
      else $error("input register readable");
   a_low_load: assert property (s_wr(CRCBU_ADDR_RESULT_LOW) |->
      ##2 crc_value[7:0] == $past(pwdata[7:0], 2))
      else $error("low byte not loaded");
   a_high_load: assert property (s_wr(CRCBU_ADDR_RESULT_HIGH) |->
      ##2 crc_value[15:8] == $past(pwdata[7:0], 2))
      else $error("high byte not loaded");
endmodule
bind crcbu_top crcbu_properties u_crcbu_properties (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .crc_value(crc_value)
);
`default_nettype wire

/* testbench/tb_top.sv */
/* self-checking bench for crcbu_top over apb.
 assumes a 200 mhz clock and a sync active-high reset. */
`default_nettype none
module tb_top import crcbu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_LO = 32'(CRCBU_ADDR_RESULT_LOW);
   localparam logic [31:0] A_HI = 32'(CRCBU_ADDR_RESULT_HIGH);
   localparam logic [31:0] A_IN = 32'(CRCBU_ADDR_DATA_INPUT);
   logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic [15:0] crc_value, exp_c;
   logic [7:0] b;
   int fail_count = 0, checks_done = 0, cyc = 0;
   string msg = "123456789";
   crcbu_top u_crcbu_top (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .crc_value(crc_value)
   );
   // free-running clock
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic test_done();
      if (fail_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // reflected crc16 step, lsb first
   function automatic logic [15:0] step(logic [15:0] c, logic [7:0] d);
      c = c ^ {8'h0, d};
      for (int i = 0; i < 8; i++)
         c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      return c;
   endfunction
   task automatic feed(input logic [7:0] d);
      apb(1, A_IN, {24'h0, d}, 4'hf);
      exp_c = step(exp_c, d);
   endtask
   task automatic cmp_crc();
      apb(0, A_LO, 0, 4'hf);
      chk("low", rd, {24'h0, exp_c[7:0]});
      chk("low_err", {31'h0, err}, 0);
      apb(0, A_HI, 0, 4'hf);
      chk("high", rd, {24'h0, exp_c[15:8]});
      chk("value", {16'h0, crc_value}, {16'h0, exp_c});
   endtask
   // main sequence
   initial begin
      void'($urandom(47599));
      repeat (2) @(posedge sys_clk);
      sys_rst <= 0;
      exp_c = 16'hffff;
      cmp_crc();
      apb(0, A_IN, 0, 4'hf);
      chk("in_read", rd, 0);
      for (int i = 0; i < 9; i++)
         feed(msg[i]);
      apb(0, A_LO, 0, 4'hf);
      chk("vec_low", rd, 32'h37);
      apb(0, A_HI, 0, 4'hf);
      chk("vec_high", rd, 32'h4b);
      repeat (20) begin
         b = 8'($urandom);
         if ($urandom_range(3) == 0) begin
            exp_c = 16'($urandom);
            apb(1, A_LO, {24'h0, exp_c[7:0]}, 4'hf);
            apb(1, A_HI, {24'h0, exp_c[15:8]}, 4'hf);
         end
         feed(b);
         cmp_crc();
      end
      apb(1, A_IN, 32'h5a, 4'h0);
      apb(1, 32'h628, 32'h1, 4'hf);
      chk("err", {31'h0, err}, 1);
      // write without the low strobe is ignored; checked by the next compare
      apb(1, A_LO, 32'h00, 4'he);
      // upper address bits set: unmapped, reads zero with an error
      apb(0, 32'h0001_061c, 0, 4'hf);
      chk("hi_addr_err", {31'h0, err}, 1);
      chk("hi_addr_rd", rd, 0);
      feed(8'h00);
      feed(8'hff);
      cmp_crc();
      sys_rst <= 1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 0;
      exp_c = 16'hffff;
      cmp_crc();
      test_done();
   end
endmodule
`default_nettype wire
